/* logic/swt_pkg.sv */
// Constants shared by the suspend/wake clock controller and its wake-up timer.
// Assumes a 125 MHz system clock that keeps running as the low-power timebase.
package swt_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS  = 8000;
   localparam int unsigned T_INT_HOLD_NS  = 8000;
   localparam int unsigned T_EXT_SHORT_US = 128;
   localparam int unsigned T_EXT_LONG_MS  = 4;
   localparam int unsigned T_BASE_WAKE_US = 1000;
   // Least times: hold and short delay round up to whole cycles; long delay and base period truncate
   localparam int unsigned INT_HOLD_CYC =
      (T_INT_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned EXT_SHORT_CYC_DEF =
      (T_EXT_SHORT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned EXT_LONG_CYC_DEF =
      (T_EXT_LONG_MS * 1000 * 1000000 / CLK_PERIOD_PS);
   localparam int unsigned BASE_WAKE_CYC_DEF =
      (T_BASE_WAKE_US * 1000000 / CLK_PERIOD_PS);
   localparam int unsigned DLY_W  = 20;
   localparam int unsigned BASE_W = 20;
   localparam int unsigned ADJ_W  = 3;
   localparam int unsigned MULT_W = 7;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int unsigned ADR_W  = 8;
   localparam int unsigned DAT_W  = 32;
   localparam logic [7:0] A_CLK_CFG  = 8'h00;
   localparam logic [7:0] A_PSC      = 8'h04;
   localparam logic [7:0] A_INT_EN   = 8'h08;
   localparam logic [7:0] A_INT_STAT = 8'h0C;
   localparam logic [7:0] A_INT_MASK = 8'h10;
   localparam logic [7:0] A_STATE    = 8'h14;

   // Clock configuration fields
   localparam int unsigned CFG_EXT_OSC = 0;
   localparam int unsigned CFG_RES_DLY = 1;
   localparam int unsigned CFG_ADJ_LSB = 4;
   // Processor status/control fields
   localparam int unsigned PSC_RUN  = 0;
   localparam int unsigned PSC_SUSP = 3;
   // State readback field: running on the external clock
   localparam int unsigned STATE_EXT_BIT = 8;
   // Interrupt enable field
   localparam int unsigned IEN_WAKE = 0;
   // Event bits of status and mask
   localparam int unsigned EV_W      = 3;
   localparam int unsigned EV_TICK   = 0;
   localparam int unsigned EV_RESUME = 1;
   localparam int unsigned EV_STABLE = 2;

   localparam logic [ADJ_W-1:0] ADJ_RST = 3'h0;
   localparam logic [EV_W-1:0]  EV_RST  = 3'h0;

   // ----------------------------------------------------------------
   // Controller states
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_RUN       = 5'b0_0001,
      ST_SUSP      = 5'b0_0010,
      ST_INT_HOLD  = 5'b0_0100,
      ST_EXT_WAIT  = 5'b0_1000,
      ST_EXT_DELAY = 5'b1_0000
   } swt_state_e;

endpackage

/* logic/swt_wake_timer.sv */
// Periodic wake-up timer: base period times two to the power of the adjust code.
// Assumes its clock keeps running during suspend as the low-power timebase.
`timescale 1ns/10ps
module swt_wake_timer #(
   parameter int unsigned BASE_CYC = swt_pkg::BASE_WAKE_CYC_DEF
) (
   input  wire logic                     clk_in,
   input  wire logic                     reset_n_in,
   input  wire logic                     enable_in,
   input  wire logic [swt_pkg::ADJ_W-1:0] adjust_in,
   output logic                          tick_out
);
   import swt_pkg::*;

   logic [BASE_W-1:0] base_cnt;
   logic [MULT_W-1:0] mult_cnt;
   logic              tick;
   logic [BASE_W-1:0] next_base_cnt;
   logic [MULT_W-1:0] next_mult_cnt;
   logic              next_tick;
   logic [MULT_W:0]   mult_top;

   // ----------------------------------------------------------------
   // Counters
   // ----------------------------------------------------------------
   always_comb begin
      mult_top      = (MULT_W+1)'(1) << adjust_in;
      next_base_cnt = base_cnt;
      next_mult_cnt = mult_cnt;
      next_tick     = 1'b0;
      if (!enable_in) begin
         // Disabling clears the count so a new enable yields a full period
         next_base_cnt = '0;
         next_mult_cnt = '0;
      end else if (base_cnt == BASE_W'(BASE_CYC - 1)) begin
         next_base_cnt = '0;
         if ({1'b0, mult_cnt} >= mult_top - 1'b1) begin
            next_mult_cnt = '0;
            next_tick     = 1'b1;
         end else begin
            next_mult_cnt = mult_cnt + 1'b1;
         end
      end else begin
         next_base_cnt = base_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         base_cnt <= '0;
         mult_cnt <= '0;
         tick     <= 1'b0;
      end else begin
         base_cnt <= next_base_cnt;
         mult_cnt <= next_mult_cnt;
         tick     <= next_tick;
      end
   end

   assign tick_out = tick;

endmodule

/* logic/swt_ctrl.sv */
// Suspend/wake clock controller with Wishbone register slave and wake-up timer.
// Assumes a classic Wishbone master and async wake and oscillator-stable pins.
`timescale 1ns/10ps
module swt_ctrl #(
   parameter int unsigned EXT_SHORT_CYC = swt_pkg::EXT_SHORT_CYC_DEF,
   parameter int unsigned EXT_LONG_CYC  = swt_pkg::EXT_LONG_CYC_DEF,
   parameter int unsigned BASE_WAKE_CYC = swt_pkg::BASE_WAKE_CYC_DEF
) (
   input  wire logic                     CLK_IN,
   input  wire logic                     RESET_N_IN,
   input  wire logic                     WB_CYC_IN,
   input  wire logic                     WB_STB_IN,
   input  wire logic                     WB_WE_IN,
   input  wire logic [swt_pkg::ADR_W-1:0] WB_ADR_IN,
   input  wire logic [3:0]               WB_SEL_IN,
   input  wire logic [swt_pkg::DAT_W-1:0] WB_DAT_IN,
   output logic      [swt_pkg::DAT_W-1:0] WB_DAT_OUT,
   output logic                          WB_ACK_OUT,
   input  wire logic                     WAKE_EVENT_IN,
   input  wire logic                     EXT_CLK_STABLE_IN,
   output logic                          INT_CLK_EN_OUT,
   output logic                          EXT_OSC_EN_OUT,
   output logic                          EXEC_HOLD_OUT,
   output logic                          SUSPENDED_OUT,
   output logic                          WAKE_TICK_OUT,
   output logic                          IRQ_OUT
);
   import swt_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic              wake_meta, wake_sync, stab_meta, stab_sync;
   logic              tick;
   logic              ack;
   logic [DAT_W-1:0]  rdata;
   logic              cfg_ext, cfg_res_dly, run, ien_wake;
   logic [ADJ_W-1:0]  cfg_adj;
   logic [EV_W-1:0]   stat, mask;
   logic              irq;
   logic              next_ack;
   logic [DAT_W-1:0]  next_rdata;
   logic              next_cfg_ext, next_cfg_res_dly, next_run, next_ien_wake;
   logic [ADJ_W-1:0]  next_cfg_adj;
   logic [EV_W-1:0]   next_stat, next_mask, ev_set;
   logic              next_irq;
   logic              req, wr, susp_req;
   swt_state_e        state, next_state;
   logic [DLY_W-1:0]  dly, next_dly;
   logic              src_ext, next_src_ext;
   logic              sel_ext, next_sel_ext;
   logic              wake_pend, next_wake_pend;
   logic              wake_now;
   logic              int_clk, ext_osc, hold, susp;
   logic              next_int_clk, next_ext_osc, next_hold, next_susp;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         wake_meta <= 1'b0;
         wake_sync <= 1'b0;
         stab_meta <= 1'b0;
         stab_sync <= 1'b0;
      end else begin
         wake_meta <= WAKE_EVENT_IN;
         wake_sync <= wake_meta;
         stab_meta <= EXT_CLK_STABLE_IN;
         stab_sync <= stab_meta;
      end
   end

   // ----------------------------------------------------------------
   // Wake-up timer
   // ----------------------------------------------------------------
   // Runs from the always-on clock in every state, gated only by its enable
   swt_wake_timer #(
      .BASE_CYC   (BASE_WAKE_CYC)
   ) u_timer (
      .clk_in     (CLK_IN),
      .reset_n_in (RESET_N_IN),
      .enable_in  (ien_wake),
      .adjust_in  (cfg_adj),
      .tick_out   (tick)
   );

   // ----------------------------------------------------------------
   // Register slave
   // ----------------------------------------------------------------
   // Answer one cycle after the strobe; writes land on the acked edge
   assign req      = WB_CYC_IN & WB_STB_IN;
   assign wr       = req & WB_WE_IN & ack & WB_SEL_IN[0];
   assign susp_req = wr && (WB_ADR_IN == A_PSC) && WB_DAT_IN[PSC_SUSP];

   always_comb begin
      next_ack         = req & ~ack;
      next_rdata       = rdata;
      next_cfg_ext     = cfg_ext;
      next_cfg_res_dly = cfg_res_dly;
      next_cfg_adj     = cfg_adj;
      next_run         = run;
      next_ien_wake    = ien_wake;
      next_mask        = mask;
      ev_set           = '0;
      ev_set[EV_TICK]  = tick;
      ev_set[EV_RESUME] = (state == ST_SUSP) && (next_state != ST_SUSP);
      ev_set[EV_STABLE] = (state == ST_EXT_WAIT) && (next_state == ST_EXT_DELAY);
      next_stat        = stat | ev_set;
      if (req && !ack && !WB_WE_IN) begin
         next_rdata = '0;
         case (WB_ADR_IN)
            A_CLK_CFG: begin
               next_rdata[CFG_EXT_OSC] = cfg_ext;
               next_rdata[CFG_RES_DLY] = cfg_res_dly;
               next_rdata[CFG_ADJ_LSB +: ADJ_W] = cfg_adj;
            end
            A_PSC: begin
               next_rdata[PSC_RUN]  = run;
               next_rdata[PSC_SUSP] = (state == ST_SUSP);
            end
            A_INT_EN: begin
               next_rdata[IEN_WAKE] = ien_wake;
            end
            A_INT_STAT: begin
               next_rdata[EV_W-1:0] = stat;
            end
            A_INT_MASK: begin
               next_rdata[EV_W-1:0] = mask;
            end
            A_STATE: begin
               next_rdata[$bits(state)-1:0] = state;
               next_rdata[STATE_EXT_BIT] = src_ext;
            end
            default: begin
               next_rdata = '0;
            end
         endcase
      end
      if (wr) begin
         case (WB_ADR_IN)
            A_CLK_CFG: begin
               next_cfg_ext     = WB_DAT_IN[CFG_EXT_OSC];
               next_cfg_res_dly = WB_DAT_IN[CFG_RES_DLY];
               next_cfg_adj     = WB_DAT_IN[CFG_ADJ_LSB +: ADJ_W];
            end
            A_PSC: begin
               next_run = WB_DAT_IN[PSC_RUN];
            end
            A_INT_EN: begin
               next_ien_wake = WB_DAT_IN[IEN_WAKE];
            end
            A_INT_STAT: begin
               // A new event in the same cycle outlives the clear
               next_stat = (stat & ~WB_DAT_IN[EV_W-1:0]) | ev_set;
            end
            A_INT_MASK: begin
               next_mask = WB_DAT_IN[EV_W-1:0];
            end
            default: begin
               next_mask = mask;
            end
         endcase
      end
      next_irq = |(next_stat & next_mask);
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ack         <= 1'b0;
         rdata       <= '0;
         cfg_ext     <= 1'b0;
         cfg_res_dly <= 1'b0;
         cfg_adj     <= ADJ_RST;
         run         <= 1'b0;
         ien_wake    <= 1'b0;
         stat        <= EV_RST;
         mask        <= EV_RST;
         irq         <= 1'b0;
      end else begin
         ack         <= next_ack;
         rdata       <= next_rdata;
         cfg_ext     <= next_cfg_ext;
         cfg_res_dly <= next_cfg_res_dly;
         cfg_adj     <= next_cfg_adj;
         run         <= next_run;
         ien_wake    <= next_ien_wake;
         stat        <= next_stat;
         mask        <= next_mask;
         irq         <= next_irq;
      end
   end

   // ----------------------------------------------------------------
   // Suspend and clock sequencing
   // ----------------------------------------------------------------
   assign wake_now = wake_sync | tick;

   always_comb begin
      next_state     = state;
      next_dly       = dly;
      next_src_ext   = src_ext;
      next_sel_ext   = sel_ext;
      next_wake_pend = wake_pend;
      case (state)
         ST_RUN: begin
            if (susp_req) begin
               // Source choice is frozen at the moment of entry
               next_state     = ST_SUSP;
               next_sel_ext   = cfg_ext;
               next_wake_pend = wake_now;
            end else if (cfg_ext && !src_ext) begin
               next_state = ST_EXT_WAIT;
            end
         end
         ST_SUSP: begin
            // A wake seen while run is clear is kept until run is set
            if (wake_now) begin
               next_wake_pend = 1'b1;
            end
            if ((wake_pend || wake_now) && run) begin
               next_wake_pend = 1'b0;
               if (sel_ext) begin
                  next_state = ST_EXT_WAIT;
               end else begin
                  next_state = ST_INT_HOLD;
                  next_dly   = DLY_W'(INT_HOLD_CYC - 1);
               end
            end
         end
         ST_INT_HOLD: begin
            if (dly == '0) begin
               next_state   = ST_RUN;
               next_src_ext = 1'b0;
            end else begin
               next_dly = dly - 1'b1;
            end
         end
         ST_EXT_WAIT: begin
            if (stab_sync) begin
               next_state = ST_EXT_DELAY;
               next_dly   = cfg_res_dly ? DLY_W'(EXT_LONG_CYC - 1)
                                        : DLY_W'(EXT_SHORT_CYC - 1);
            end
         end
         ST_EXT_DELAY: begin
            if (dly == '0) begin
               next_state   = ST_RUN;
               next_src_ext = 1'b1;
            end else begin
               next_dly = dly - 1'b1;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
      next_int_clk = (next_state == ST_INT_HOLD)
                   || ((next_state == ST_RUN) && !next_src_ext);
      // Oscillator stays dark on the internal clock until it is asked for
      next_ext_osc = (next_state == ST_EXT_WAIT) || (next_state == ST_EXT_DELAY)
                   || ((next_state == ST_RUN) && next_src_ext);
      next_hold    = (next_state != ST_RUN);
      next_susp    = (next_state == ST_SUSP);
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state     <= ST_RUN;
         dly       <= '0;
         src_ext   <= 1'b0;
         sel_ext   <= 1'b0;
         wake_pend <= 1'b0;
         int_clk   <= 1'b1;
         ext_osc   <= 1'b0;
         hold      <= 1'b0;
         susp      <= 1'b0;
      end else begin
         state     <= next_state;
         dly       <= next_dly;
         src_ext   <= next_src_ext;
         sel_ext   <= next_sel_ext;
         wake_pend <= next_wake_pend;
         int_clk   <= next_int_clk;
         ext_osc   <= next_ext_osc;
         hold      <= next_hold;
         susp      <= next_susp;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign WB_DAT_OUT     = rdata;
   assign WB_ACK_OUT     = ack;
   assign INT_CLK_EN_OUT = int_clk;
   assign EXT_OSC_EN_OUT = ext_osc;
   assign EXEC_HOLD_OUT  = hold;
   assign SUSPENDED_OUT  = susp;
   assign WAKE_TICK_OUT  = tick;
   assign IRQ_OUT        = irq;

endmodule

/* bench/swt_ctrl_sva.sv */
// Port-level checker for the suspend/wake clock controller.
// Assumes it is bound onto swt_ctrl from the bench top file.
`timescale 1ns/10ps
module swt_ctrl_sva
   import swt_pkg::*;
(
   input wire logic                      CLK_IN,
   input wire logic                      RESET_N_IN,
   input wire logic                      WB_CYC_IN,
   input wire logic                      WB_STB_IN,
   input wire logic                      WB_WE_IN,
   input wire logic [swt_pkg::ADR_W-1:0] WB_ADR_IN,
   input wire logic [3:0]                WB_SEL_IN,
   input wire logic [swt_pkg::DAT_W-1:0] WB_DAT_IN,
   input wire logic                      WB_ACK_OUT,
   input wire logic                      INT_CLK_EN_OUT,
   input wire logic                      EXT_OSC_EN_OUT,
   input wire logic                      EXEC_HOLD_OUT,
   input wire logic                      SUSPENDED_OUT,
   input wire logic                      WAKE_TICK_OUT
);
   import swt_pkg::*;
   // ----------------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------------
   logic        wr_hit;
   logic        wr_cfg;
   logic        wr_susp;
   logic [11:0] hold_cnt;
   logic [11:0] next_hold_cnt;
   assign wr_hit  = WB_CYC_IN && WB_STB_IN && WB_WE_IN && WB_ACK_OUT && WB_SEL_IN[0];
   assign wr_cfg  = wr_hit && (WB_ADR_IN == A_CLK_CFG);
   assign wr_susp = wr_hit && (WB_ADR_IN == A_PSC) && WB_DAT_IN[PSC_SUSP];
   // Counts held cycles of an internal-clock wake; saturates well past the hold time
   always_comb begin
      next_hold_cnt = 12'h000;
      if (EXEC_HOLD_OUT && !SUSPENDED_OUT && !EXT_OSC_EN_OUT) begin
         next_hold_cnt = (hold_cnt == 12'hFFF) ? hold_cnt : hold_cnt + 12'h001;
      end
   end
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         hold_cnt <= 12'h000;
      end else begin
         hold_cnt <= next_hold_cnt;
      end
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   sequence s_wb_req;
      WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
   endsequence
   sequence s_int_wake;
      $fell(SUSPENDED_OUT) ##0 !EXT_OSC_EN_OUT;
   endsequence
   sequence s_ext_start;
      $rose(EXT_OSC_EN_OUT) ##0 !$past(SUSPENDED_OUT);
   endsequence
   a_ack_next: assert property (s_wb_req |=> WB_ACK_OUT)
      else $error("ack did not follow request by one cycle");
   a_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack longer than one cycle");
   a_susp_entry: assert property (wr_susp && !EXEC_HOLD_OUT |=> SUSPENDED_OUT)
      else $error("suspend write did not suspend");
   a_susp_hold: assert property (SUSPENDED_OUT |-> EXEC_HOLD_OUT)
      else $error("execution not held in suspend");
   a_int_restart: assert property (s_int_wake |-> INT_CLK_EN_OUT)
      else $error("internal clock not restarted at wake");
   a_int_hold_len: assert property ($fell(EXEC_HOLD_OUT) && !EXT_OSC_EN_OUT
      |-> hold_cnt inside {[INT_HOLD_CYC-1:INT_HOLD_CYC+1]})
      else $error("internal wake hold length wrong");
   a_ext_cause: assert property ($rose(EXT_OSC_EN_OUT)
      |-> $past(SUSPENDED_OUT) || $past(wr_cfg) || $past(wr_cfg, 2))
      else $error("oscillator started without cause");
   a_ext_stop: assert property (s_ext_start |-> !INT_CLK_EN_OUT && EXEC_HOLD_OUT)
      else $error("internal clock not halted for oscillator start");
   a_tick_pulse: assert property (WAKE_TICK_OUT |=> !WAKE_TICK_OUT)
      else $error("tick longer than one cycle");
endmodule

/* bench/swt_ctrl_tb.sv */
// Self-checking bench for swt_ctrl: register table, timer, wake sequences.
// Assumes short delay parameters so the run stays brief.
`timescale 1ns/10ps
module swt_ctrl_tb;
   import swt_pkg::*;
   localparam int unsigned SHORT_C = 20;
   localparam int unsigned LONG_C  = 40;
   localparam int unsigned BASE_C  = 8;
   typedef struct {logic [7:0] adr; logic [31:0] wd; logic [31:0] rd;} swt_row_s;
   logic        CLK_IN = 1'b0;
   logic        RESET_N_IN = 1'b0;
   logic        WB_CYC_IN = 1'b0, WB_STB_IN = 1'b0, WB_WE_IN = 1'b0;
   logic [7:0]  WB_ADR_IN = 8'h00;
   logic [3:0]  WB_SEL_IN = 4'h0;
   logic [31:0] WB_DAT_IN = 32'h0000_0000;
   logic [31:0] WB_DAT_OUT;
   logic        WB_ACK_OUT, INT_CLK_EN_OUT, EXT_OSC_EN_OUT, EXEC_HOLD_OUT;
   logic        SUSPENDED_OUT, WAKE_TICK_OUT, IRQ_OUT;
   logic        WAKE_EVENT_IN = 1'b0, EXT_CLK_STABLE_IN = 1'b0;
   int          bad_count = 0, checked = 0, n;
   logic [31:0] q;
   swt_row_s    rows [6] = '{
      '{A_CLK_CFG, 32'hFFFF_FF72, 32'h0000_0072}, '{A_PSC, 32'h0000_0001, 32'h0000_0001},
      '{A_INT_MASK, 32'h0000_0007, 32'h0000_0007}, '{A_INT_EN, 32'h0000_0000, 32'h0000_0000},
      '{8'h40, 32'h0000_00FF, 32'h0000_0000}, '{A_STATE, 32'h0000_0000, 32'h0000_0001}};
   always #4 CLK_IN = ~CLK_IN;
   swt_ctrl #(.EXT_SHORT_CYC(SHORT_C), .EXT_LONG_CYC(LONG_C), .BASE_WAKE_CYC(BASE_C)) dut_u (
      .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
      .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN),
      .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
      .WAKE_EVENT_IN(WAKE_EVENT_IN), .EXT_CLK_STABLE_IN(EXT_CLK_STABLE_IN),
      .INT_CLK_EN_OUT(INT_CLK_EN_OUT), .EXT_OSC_EN_OUT(EXT_OSC_EN_OUT),
      .EXEC_HOLD_OUT(EXEC_HOLD_OUT), .SUSPENDED_OUT(SUSPENDED_OUT),
      .WAKE_TICK_OUT(WAKE_TICK_OUT), .IRQ_OUT(IRQ_OUT));
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Reads at a posedge see the values registered by the previous edge
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int k;
      @(posedge CLK_IN);
      {WB_CYC_IN, WB_STB_IN, WB_WE_IN, WB_SEL_IN} <= {1'b1, 1'b1, we, 4'hF};
      WB_ADR_IN <= adr;
      WB_DAT_IN <= d;
      k = 0;
      do begin
         @(posedge CLK_IN);
         k++;
      end while (WB_ACK_OUT !== 1'b1 && k < 20);
      q = WB_DAT_OUT;
      {WB_CYC_IN, WB_STB_IN, WB_WE_IN} <= 3'b000;
      if (k >= 20) begin
         check("ack", 0, 1);
         tally_and_finish();
      end
   endtask
   // Counts cycles until the chosen output reaches lvl; bounded
   task automatic wait_lvl(input int which, input logic lvl);
      logic s;
      n = 0;
      do begin
         @(posedge CLK_IN);
         n++;
         s = (which == 0) ? SUSPENDED_OUT : (which == 1) ? EXEC_HOLD_OUT : WAKE_TICK_OUT;
      end while (s !== lvl && n < 5000);
      if (n >= 5000) begin
         check("wait", 0, 1);
         tally_and_finish();
      end
   endtask
   initial begin
      repeat (6) @(posedge CLK_IN);
      RESET_N_IN <= 1'b1;
      check("intclk", INT_CLK_EN_OUT, 1);
      check("outs", {EXT_OSC_EN_OUT, EXEC_HOLD_OUT, SUSPENDED_OUT, IRQ_OUT}, 0);
      wb(0, A_CLK_CFG, 0);
      check("adjust", q[6:4], 0);
      foreach (rows[i]) begin
         wb(1, rows[i].adr, rows[i].wd);
         wb(0, rows[i].adr, 0);
         check("reg", q, rows[i].rd);
      end
      // Every adjust code: tick spacing is the base period shifted by the code
      for (int a = 0; a < 8; a++) begin
         wb(1, A_CLK_CFG, a << 4);
         wb(1, A_INT_EN, 1);
         wait_lvl(2, 1);
         check("first", n, (BASE_C << a) + 1);
         wait_lvl(2, 0);
         wait_lvl(2, 1);
         check("period", n + 1, BASE_C << a);
         check("irq", IRQ_OUT, 1);
         wb(1, A_INT_EN, 0);
         wb(1, A_INT_STAT, 7);
         repeat (2 * (BASE_C << a)) @(posedge CLK_IN);
         check("stop", IRQ_OUT, 0);
      end
      wb(1, A_INT_MASK, 0);
      wb(1, A_CLK_CFG, 0);
      wb(1, A_INT_EN, 1);
      wait_lvl(2, 1);
      @(posedge CLK_IN);
      check("masked", IRQ_OUT, 0);
      wb(1, A_INT_EN, 0);
      wb(1, A_INT_STAT, 7);
      // Internal-clock wake, with run cleared first so the wake waits
      wb(1, A_PSC, 32'h0000_0008);
      @(posedge CLK_IN);
      check("susp", SUSPENDED_OUT, 1);
      WAKE_EVENT_IN <= 1'b1;
      repeat (20) @(posedge CLK_IN);
      check("runoff", SUSPENDED_OUT, 1);
      wb(1, A_PSC, 1);
      wait_lvl(0, 0);
      WAKE_EVENT_IN <= 1'b0;
      check("int", {INT_CLK_EN_OUT, EXT_OSC_EN_OUT}, 2'b10);
      wait_lvl(1, 0);
      check("hold8us", (n >= INT_HOLD_CYC - 1 && n <= INT_HOLD_CYC + 1), 1);
      wb(0, A_INT_STAT, 0);
      check("resumed", q[EV_RESUME], 1);
      // Switch to external clock while running internally
      wb(1, A_CLK_CFG, 1);
      repeat (3) @(posedge CLK_IN);
      check("halt", {INT_CLK_EN_OUT, EXT_OSC_EN_OUT, EXEC_HOLD_OUT}, 3'b011);
      EXT_CLK_STABLE_IN <= 1'b1;
      wait_lvl(1, 0);
      check("short", (n >= SHORT_C && n <= SHORT_C + 4), 1);
      wb(0, A_STATE, 0);
      check("state", q, 32'h0000_0101);
      // External-clock wake with the long delay selected
      wb(1, A_CLK_CFG, 3);
      wb(1, A_PSC, 32'h0000_0009);
      EXT_CLK_STABLE_IN <= 1'b0;
      repeat (5) @(posedge CLK_IN);
      WAKE_EVENT_IN <= 1'b1;
      wait_lvl(0, 0);
      WAKE_EVENT_IN <= 1'b0;
      repeat (5) @(posedge CLK_IN);
      check("extwait", {EXT_OSC_EN_OUT, EXEC_HOLD_OUT}, 2'b11);
      EXT_CLK_STABLE_IN <= 1'b1;
      wait_lvl(1, 0);
      check("long", (n >= LONG_C && n <= LONG_C + 4), 1);
      // Timer alone wakes a suspended part on the internal clock
      wb(1, A_CLK_CFG, 0);
      wb(1, A_INT_EN, 1);
      wb(1, A_PSC, 32'h0000_0009);
      wait_lvl(0, 0);
      check("tickwake", (n <= BASE_C), 1);
      check("tickclk", {INT_CLK_EN_OUT, EXT_OSC_EN_OUT}, 2'b10);
      // Reset in mid-hold returns outputs and registers to their reset values
      RESET_N_IN <= 1'b0;
      repeat (6) @(posedge CLK_IN);
      RESET_N_IN <= 1'b1;
      check("rstclk", {INT_CLK_EN_OUT, EXT_OSC_EN_OUT}, 2'b10);
      check("rstouts", {EXEC_HOLD_OUT, SUSPENDED_OUT, IRQ_OUT, WAKE_TICK_OUT}, 0);
      wb(0, A_STATE, 0);
      check("rststate", q, 32'h0000_0001);
      wb(0, A_INT_EN, 0);
      check("rsten", q, 32'h0000_0000);
      tally_and_finish();
   end
endmodule
bind swt_ctrl swt_ctrl_sva chk_u (
   .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
   .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN),
   .WB_DAT_IN(WB_DAT_IN), .WB_ACK_OUT(WB_ACK_OUT), .INT_CLK_EN_OUT(INT_CLK_EN_OUT),
   .EXT_OSC_EN_OUT(EXT_OSC_EN_OUT), .EXEC_HOLD_OUT(EXEC_HOLD_OUT),
   .SUSPENDED_OUT(SUSPENDED_OUT), .WAKE_TICK_OUT(WAKE_TICK_OUT));
